// file: core/osg_pkg.sv
// constants and carrier types for the oscillator standby output gating block
package osg_pkg;

  // internal oscillator clock
  localparam int unsigned OSG_CLK_PERIOD_NS = 8;

  // output clock shape in oscillator cycles (factory programmed divide)
  localparam int unsigned OSG_HALF_CYCLES = 4;
  localparam int unsigned OSG_PERIOD_CYCLES = 2 * OSG_HALF_CYCLES;
  localparam int unsigned OSG_PH_W = 3;
  localparam logic [OSG_PH_W-1:0] OSG_PH_LAST = OSG_PH_W'(OSG_PERIOD_CYCLES - 1);
  localparam logic [OSG_PH_W-1:0] OSG_PH_HALF = OSG_PH_W'(OSG_HALF_CYCLES);
  localparam logic [OSG_PH_W-1:0] OSG_PH_RESET = 3'h0;

  // startup settle: typical 75 ms, limit 150 ms; counts use the typical times
  localparam int unsigned OSG_STARTUP_TIME_MS = 75;
  localparam int unsigned OSG_STARTUP_LIMIT_MS = 150;
  // resume settle: typical 2 ms, limit 3 ms
  localparam int unsigned OSG_RESUME_TIME_MS = 2;
  localparam int unsigned OSG_RESUME_LIMIT_MS = 3;
  localparam int unsigned OSG_NS_PER_MS = 1000000;

  localparam int unsigned OSG_WAIT_W = 25;
  localparam logic [OSG_WAIT_W-1:0] OSG_STARTUP_CYCLES =
    OSG_WAIT_W'(OSG_STARTUP_TIME_MS * OSG_NS_PER_MS / OSG_CLK_PERIOD_NS);
  localparam logic [OSG_WAIT_W-1:0] OSG_RESUME_CYCLES =
    OSG_WAIT_W'(OSG_RESUME_TIME_MS * OSG_NS_PER_MS / OSG_CLK_PERIOD_NS);
  localparam logic [OSG_WAIT_W-1:0] OSG_WAIT_ZERO = 25'h0000000;

  // operating modes of the controller
  typedef enum logic [2:0] {
    OSG_MODE_POWERUP,
    OSG_MODE_ACTIVE,
    OSG_MODE_DRAIN,
    OSG_MODE_STANDBY,
    OSG_MODE_RESUME
  } osg_state_e;

  // controller to output gate
  typedef struct packed {
    logic run;     // synthesizer powered, divider counting
    logic en_req;  // output wanted
  } osg_gate_ctl_s;

  // output gate back to controller and pins
  typedef struct packed {
    logic idle;    // gate closed, safe to stop the divider
    logic out;     // clock level on the pin
    logic oe;      // pin driven
  } osg_gate_sts_s;

endpackage

// file: core/osg_clk_gate.sv
// output divider and glitch-free clock gate
`timescale 1ns/1ps
module osg_clk_gate (
  input wire logic clk,
  input wire logic reset_n,
  input wire osg_pkg::osg_gate_ctl_s ctl,
  output osg_pkg::osg_gate_sts_s sts
);
  import osg_pkg::*;

  logic [OSG_PH_W-1:0] ph_q;
  logic [OSG_PH_W-1:0] ph_d;
  logic gate_q;
  logic gate_d;
  logic out_q;
  logic out_d;

  // divider phase; held at zero while the synthesizer is powered down
  always_comb begin
    ph_d = OSG_PH_RESET;
    if (ctl.run) begin
      ph_d = (ph_q == OSG_PH_LAST) ? OSG_PH_RESET : ph_q + 3'h1;
    end
  end

  // open only at the start of a high half, close only after a whole low half
  always_comb begin
    gate_d = gate_q;
    if (!gate_q && ctl.en_req && ctl.run && ph_d == OSG_PH_RESET) begin
      gate_d = 1'b1;
    end else if (gate_q && !ctl.en_req && ph_q == OSG_PH_LAST) begin
      gate_d = 1'b0;
    end
    out_d = gate_d && (ph_d < OSG_PH_HALF);
  end

  // registered so the pin never sees a decode glitch
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ph_q <= OSG_PH_RESET;
      gate_q <= 1'b0;
      out_q <= 1'b0;
    end else begin
      ph_q <= ph_d;
      gate_q <= gate_d;
      out_q <= out_d;
    end
  end

  assign sts.idle = !gate_q;
  assign sts.out = out_q;
  assign sts.oe = gate_q;

endmodule

// file: core/osg_mode_ctrl.sv
// mode controller for the oscillator: startup, standby, resume and output gating
`timescale 1ns/1ps
module osg_mode_ctrl #(
  parameter logic [osg_pkg::OSG_WAIT_W-1:0] STARTUP_CYCLES = osg_pkg::OSG_STARTUP_CYCLES,
  parameter logic [osg_pkg::OSG_WAIT_W-1:0] RESUME_CYCLES = osg_pkg::OSG_RESUME_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic standby_select,
  input wire logic blocks_ready,
  output logic clk_out,
  output logic clk_out_oe,
  output logic synth_pwr_en,
  output logic standby_mode
);
  import osg_pkg::*;

  logic sel_meta_q;
  logic sel_sync_q;
  osg_state_e state_q;
  osg_state_e state_d;
  logic [OSG_WAIT_W-1:0] wait_q;
  logic [OSG_WAIT_W-1:0] wait_d;
  logic pwr_q;
  logic pwr_d;
  logic stby_q;
  logic stby_d;
  osg_gate_ctl_s gate_ctl;
  osg_gate_sts_s gate_sts;

  // two-flop synchroniser; a floating pin resolves low outside
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sel_meta_q <= 1'b0;
      sel_sync_q <= 1'b0;
    end else begin
      sel_meta_q <= standby_select;
      sel_sync_q <= sel_meta_q;
    end
  end

  // mode sequencing; the wait counter counts down to zero
  always_comb begin
    state_d = state_q;
    wait_d = (wait_q != OSG_WAIT_ZERO) ? wait_q - 25'h0000001 : OSG_WAIT_ZERO;
    unique case (state_q)
      OSG_MODE_POWERUP: begin
        // output held off until the synthesizer has settled
        if (wait_q == OSG_WAIT_ZERO && blocks_ready) begin
          if (sel_sync_q) begin
            state_d = OSG_MODE_STANDBY;
          end else begin
            state_d = OSG_MODE_ACTIVE;
          end
        end
      end
      OSG_MODE_ACTIVE: begin
        if (sel_sync_q) begin
          state_d = OSG_MODE_DRAIN;
        end
      end
      OSG_MODE_DRAIN: begin
        // let the last cycle finish before powering down
        if (gate_sts.idle) begin
          state_d = OSG_MODE_STANDBY;
        end
      end
      OSG_MODE_STANDBY: begin
        if (!sel_sync_q) begin
          state_d = OSG_MODE_RESUME;
          wait_d = RESUME_CYCLES;
        end
      end
      OSG_MODE_RESUME: begin
        if (sel_sync_q) begin
          state_d = OSG_MODE_STANDBY;
        end else if (wait_q == OSG_WAIT_ZERO && blocks_ready) begin
          state_d = OSG_MODE_ACTIVE;
        end
      end
      default: begin
        state_d = OSG_MODE_POWERUP;
        wait_d = STARTUP_CYCLES;
      end
    endcase
    // everything but oscillator and select detection off in standby
    pwr_d = (state_d != OSG_MODE_STANDBY);
    stby_d = (state_d == OSG_MODE_STANDBY);
  end

  // registered mode state; reset is the power-on event
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q <= OSG_MODE_POWERUP;
      wait_q <= STARTUP_CYCLES;
      pwr_q <= 1'b1;
      stby_q <= 1'b0;
    end else begin
      state_q <= state_d;
      wait_q <= wait_d;
      pwr_q <= pwr_d;
      stby_q <= stby_d;
    end
  end

  // the gate only ever opens while active; drain keeps the divider running
  assign gate_ctl.run = pwr_q;
  assign gate_ctl.en_req = (state_q == OSG_MODE_ACTIVE);

  osg_clk_gate u_gate (
    .clk(clk),
    .reset_n(reset_n),
    .ctl(gate_ctl),
    .sts(gate_sts)
  );

  // pin drivers straight from the gate flops; weak pull-down lives outside
  assign clk_out = gate_sts.out;
  assign clk_out_oe = gate_sts.oe;
  assign synth_pwr_en = pwr_q;
  assign standby_mode = stby_q;

  // checks next to the logic they guard

  // a full first period: high half then low half
  sequence s_high_half;
    clk_out [*4];
  endsequence

  sequence s_low_half;
    !clk_out [*4];
  endsequence

  sequence s_low_tail;
    (clk_out_oe && !clk_out) [*4];
  endsequence

  // nine settled active samples; the gate may wait a whole period for phase zero
  sequence s_active_settled;
    (state_q == OSG_MODE_ACTIVE && !sel_sync_q) [*8] ##1 (state_q == OSG_MODE_ACTIVE && !sel_sync_q);
  endsequence

  AST_ACTIVE_DRIVES: assert property (
    @(posedge clk) disable iff (!reset_n)
    s_active_settled |-> clk_out_oe
  ) else $error("active mode without driven output");

  AST_STANDBY_QUIET: assert property (
    @(posedge clk) disable iff (!reset_n)
    state_q == OSG_MODE_STANDBY |-> !clk_out_oe && !clk_out && standby_mode
  ) else $error("output driven in standby");

  AST_STANDBY_PWRDN: assert property (
    @(posedge clk) disable iff (!reset_n)
    $rose(standby_mode) |-> !synth_pwr_en ##1 (!synth_pwr_en || !standby_mode)
  ) else $error("synthesizer powered in standby");

  AST_STARTUP_HOLD: assert property (
    @(posedge clk) disable iff (!reset_n)
    (state_q == OSG_MODE_POWERUP || state_q == OSG_MODE_RESUME) |-> !clk_out_oe
  ) else $error("output enabled before settle");

  AST_SETTLE_HOLD: assert property (
    @(posedge clk) disable iff (!reset_n)
    state_q == OSG_MODE_POWERUP && wait_q != OSG_WAIT_ZERO |=> state_q == OSG_MODE_POWERUP
  ) else $error("power-up left before settle count ended");

  AST_SETTLE_BOUND: assert property (
    @(posedge clk) disable iff (!reset_n)
    state_q == OSG_MODE_POWERUP && wait_q == OSG_WAIT_ZERO && blocks_ready |=> state_q != OSG_MODE_POWERUP
  ) else $error("power-up not left after settle count");

  AST_RESUME_ENTER: assert property (
    @(posedge clk) disable iff (!reset_n)
    state_q == OSG_MODE_STANDBY && !sel_sync_q |=> state_q == OSG_MODE_RESUME && !clk_out_oe
  ) else $error("resume not entered");

  AST_RESUME_DONE: assert property (
    @(posedge clk) disable iff (!reset_n)
    state_q == OSG_MODE_RESUME && wait_q == OSG_WAIT_ZERO && blocks_ready && !sel_sync_q
      |=> state_q == OSG_MODE_ACTIVE ##[1:9] clk_out_oe
  ) else $error("resume did not enable output");

  AST_FIRST_CYCLE: assert property (
    @(posedge clk) disable iff (!reset_n)
    $rose(clk_out_oe) |-> s_high_half ##1 s_low_half
  ) else $error("first output cycle not full");

  AST_NO_RUNT_START: assert property (
    @(posedge clk) disable iff (!reset_n)
    $rose(clk_out_oe) |-> clk_out && $past(state_q) == OSG_MODE_ACTIVE
  ) else $error("output opened mid-cycle");

  AST_SYNC_DELAY: assert property (
    @(posedge clk) disable iff (!reset_n)
    $rose(standby_select) ##1 standby_select |=> sel_sync_q
  ) else $error("select not synchronised in two cycles");

  AST_STANDBY_TIME: assert property (
    @(posedge clk) disable iff (!reset_n)
    state_q == OSG_MODE_ACTIVE && sel_sync_q |-> ##[1:9] !clk_out_oe
  ) else $error("standby took too long to quiet output");

  AST_CLEAN_STOP: assert property (
    @(posedge clk) disable iff (!reset_n)
    s_low_tail ##1 !clk_out_oe |-> $past(state_q) == OSG_MODE_DRAIN
  ) else $error("output stopped outside drain");

  AST_STOP_AFTER_LOW: assert property (
    @(posedge clk) disable iff (!reset_n)
    $fell(clk_out_oe) |-> $past(clk_out, 1) == 1'b0 && $past(clk_out, 4) == 1'b0
  ) else $error("last output cycle truncated");

endmodule

// file: bench/osg_host_model.sv
// host side model: resolves select and clock pins, measures delivered pulses
`timescale 1ns/1ps
module osg_host_model (
  input wire logic clk,
  input wire logic clk_out,
  input wire logic clk_out_oe,
  input wire logic sel_drive,
  input wire logic sel_level,
  output logic standby_select,
  output logic pin_level,
  output logic [7:0] pulses,
  output logic [7:0] runts
);
  import osg_pkg::*;
  // counters start from zero once; no second process writes them
  logic [7:0] hi_cnt = 8'h00;
  logic [7:0] pulse_cnt = 8'h00;
  logic [7:0] runt_cnt = 8'h00;
  assign pulses = pulse_cnt;
  assign runts = runt_cnt;
  // an undriven select pin reads low through the pull-down
  assign standby_select = sel_drive ? sel_level : 1'b0;
  // a released clock pin sits at the weak pull-down level
  assign pin_level = (clk_out_oe === 1'b1) ? clk_out : 1'b0;
  // every high phase must last exactly a half period, else it is a runt
  always @(posedge clk) begin
    hi_cnt <= (pin_level === 1'b1) ? hi_cnt + 8'h01 : 8'h00;
    if (hi_cnt != 8'h00 && pin_level !== 1'b1) begin
      pulse_cnt <= pulse_cnt + 8'h01;
      if (hi_cnt != 8'(OSG_HALF_CYCLES)) begin
        runt_cnt <= runt_cnt + 8'h01;
      end
    end
  end
endmodule

// file: bench/tb.sv
// testbench for the oscillator standby output gating block
`timescale 1ns/1ps
module tb;
  import osg_pkg::*;
  logic clk, reset_n, blocks_ready, sel_drive, sel_level;
  logic standby_select, clk_out, clk_out_oe, synth_pwr_en, standby_mode, pin_level;
  logic [7:0] pulses, runts, p0;
  int mismatches, n_tests, cycles, n;
  osg_mode_ctrl #(.STARTUP_CYCLES(25'h0000004), .RESUME_CYCLES(25'h0000003)) dut_u (
    .clk(clk), .reset_n(reset_n), .standby_select(standby_select), .blocks_ready(blocks_ready),
    .clk_out(clk_out), .clk_out_oe(clk_out_oe), .synth_pwr_en(synth_pwr_en), .standby_mode(standby_mode));
  osg_host_model host_u (
    .clk(clk), .clk_out(clk_out), .clk_out_oe(clk_out_oe), .sel_drive(sel_drive), .sel_level(sel_level),
    .standby_select(standby_select), .pin_level(pin_level), .pulses(pulses), .runts(runts));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    if (mismatches == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // hang guard, runs well past the longest sequence
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      $display("unexpected at %0t: cycles %h limit %h", $time, cycles, 3000);
      end_sim;
    end
  end
  task automatic do_reset(input logic rdy, input logic sel);
    @(negedge clk);
    reset_n = 1'b0;
    blocks_ready = rdy;
    sel_drive = 1'b1;
    sel_level = sel;
    repeat (3) @(negedge clk);
    reset_n = 1'b1;
  endtask
  // bounded wait for the output enable, n returns cycles spent
  task automatic wait_oe(input logic lvl, input int lim);
    n = 0;
    while (clk_out_oe !== lvl && n < lim) begin
      @(negedge clk);
      n++;
    end
    chk(8'(clk_out_oe), 8'(lvl));
  endtask
  // enable comes late enough and starts on a full high phase
  task automatic t_startup;
    do_reset(1'b1, 1'b0);
    wait_oe(1'b1, 24);
    chk(8'(n >= 4), 8'h01);
    chk(8'(clk_out), 8'h01);
    chk(8'({synth_pwr_en, standby_mode}), 8'h02);
    p0 = pulses;
    repeat (32) @(negedge clk);
    chk(pulses - p0, 8'h04);
  endtask
  task automatic t_standby;
    // drive the pin again; the float scenario leaves it released
    sel_drive = 1'b1;
    sel_level = 1'b1;
    wait_oe(1'b0, 16);
    @(negedge clk);
    chk(8'({standby_mode, synth_pwr_en, pin_level}), 8'h04);
    chk(runts, 8'h00);
  endtask
  // release the select pin altogether; it must read as low
  task automatic t_resume_float;
    sel_drive = 1'b0;
    wait_oe(1'b1, 24);
    chk(8'(n >= 3), 8'h01);
    chk(8'({standby_mode, clk_out}), 8'h01);
    repeat (24) @(negedge clk);
    chk(runts, 8'h00);
  endtask
  // a short low on select, then high again mid resume
  task automatic t_abort;
    logic bad;
    bad = 1'b0;
    sel_drive = 1'b1;
    sel_level = 1'b0;
    repeat (2) @(negedge clk);
    sel_level = 1'b1;
    repeat (16) begin
      @(negedge clk);
      bad = bad | (clk_out_oe !== 1'b0);
    end
    chk(8'(bad), 8'h00);
    chk(8'(standby_mode), 8'h01);
  endtask
  // not ready blocks hold the output off after settle
  task automatic t_not_ready;
    do_reset(1'b0, 1'b0);
    repeat (30) @(negedge clk);
    chk(8'(clk_out_oe), 8'h00);
    blocks_ready = 1'b1;
    wait_oe(1'b1, 12);
    chk(8'(clk_out), 8'h01);
  endtask
  // select high through power-up goes straight to standby
  task automatic t_boot_standby;
    do_reset(1'b1, 1'b1);
    // the reset cut the running pulse short; only later pulses count
    p0 = runts;
    repeat (16) @(negedge clk);
    chk(8'({standby_mode, clk_out_oe, pin_level}), 8'h04);
    chk(runts - p0, 8'h00);
  endtask
  initial begin
    mismatches = 0;
    n_tests = 0;
    cycles = 0;
    reset_n = 1'b0;
    blocks_ready = 1'b0;
    sel_drive = 1'b1;
    sel_level = 1'b0;
    t_startup;
    t_standby;
    t_resume_float;
    t_standby;
    t_abort;
    t_not_ready;
    t_boot_standby;
    end_sim;
  end
endmodule
